// *** shared/toe_pkg.sv ***
// Constants, register map and field layouts of the T1 overhead extract and insert block.
package toe_pkg;

   // ------------------------------------------------------------------
   // Register map: word index on the Avalon-MM address.
   // ------------------------------------------------------------------
   localparam int         ADDR_W      = 8;
   localparam logic [7:0] OFS_RXC_LO  = 8'h56;
   localparam logic [7:0] OFS_RXMC    = 8'h57;
   localparam logic [7:0] OFS_RXSA    = 8'h58;
   localparam logic [7:0] OFS_IRQ_EN  = 8'h5c;
   localparam logic [7:0] OFS_FLAGS   = 8'h5d;
   localparam logic [7:0] OFS_FMT     = 8'h60;
   localparam logic [7:0] OFS_MODE    = 8'h62;
   localparam logic [7:0] OFS_TXC_LO  = 8'h65;
   localparam logic [7:0] OFS_TXMC    = 8'h66;
   localparam logic [7:0] OFS_TXSA    = 8'h67;
   localparam logic [7:0] OFS_YEL     = 8'h6b;
   localparam logic [7:0] OFS_MAINT   = 8'h6c;
   localparam logic [7:0] RST_VAL     = 8'h00;

   // ------------------------------------------------------------------
   // Field positions.
   // ------------------------------------------------------------------
   localparam int IRQ_DEB_BIT = 4;
   localparam int MODE_GENOFF = 0;
   localparam int MODE_CRCOFF = 1;
   localparam int MODE_DLBYP  = 2;
   localparam int FMT_J1_BIT  = 2;
   localparam int YEL_AUTO    = 1;
   localparam int YEL_MAN     = 0;
   localparam int MNT_MIMIC   = 3;
   localparam int MNT_SLIP    = 2;
   localparam int MNT_ZERO    = 1;
   localparam int MNT_ONES    = 0;

   // Overhead vector: C at 10..0, M at 13..11, A at 15..14, S at 19..16.
   // Masks are indexed by change flag: 0 C, 1 M, 2 S, 3 A.
   localparam logic [3:0][19:0] FIELD_MASK = {20'h0c000, 20'hf0000, 20'h03800, 20'h007ff};

   // ------------------------------------------------------------------
   // Frame structure and framing patterns.
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {TOE_SF, TOE_ESF, TOE_DM, TOE_SLC} toe_format_type;

   localparam logic [7:0]  FRAME_LAST      = 8'hc0;
   localparam logic [7:0]  DBIT_POS        = 8'hbe;
   localparam logic [7:0]  MIMIC_POS       = 8'h01;
   localparam logic [2:0]  YEL_CH_BIT      = 3'h2;
   localparam logic [6:0]  SF_LAST         = 7'h0b;
   localparam logic [6:0]  ESF_LAST        = 7'h17;
   localparam logic [6:0]  SLC_LAST        = 7'h47;
   localparam logic [5:0]  FS_SF_PATTERN   = 6'h1c;
   localparam logic [5:0]  FAS_PATTERN     = 6'h34;
   localparam logic [11:0] SLC_SYNC        = 12'he38;
   localparam logic [5:0]  SLC_C_FIRST     = 6'h0b;
   localparam logic [5:0]  SLC_SPARE_FIRST = 6'h1f;
   localparam logic [5:0]  SLC_SYNC_LAST   = 6'h23;
   localparam logic [15:0] IDLE_T1         = 16'hffff;
   localparam logic [15:0] IDLE_J1         = 16'hff7e;
   localparam logic [15:0] ESF_YELLOW      = 16'hff00;
   localparam logic [5:0]  CRC_POLY        = 6'h03;

endpackage : toe_pkg

// *** src/toe_overhead.sv ***
// T1 overhead extraction, change indication and transmit overhead insertion for one channel.
//
// Register access over Avalon-MM was chosen for this implementation.
module toe_overhead (
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        rx_slc_sync,
   input  wire logic        rx_frame_end,
   input  wire logic [10:0] rx_concentrator,
   input  wire logic [2:0]  rx_maint,
   input  wire logic [1:0]  rx_alarm,
   input  wire logic [3:0]  rx_switch,
   input  wire logic        rx_red_alarm,
   input  wire logic        tx_bit_en,
   input  wire logic        tx_data_in,
   input  wire logic        tx_dl_valid,
   input  wire logic        tx_dl_bit,
   output logic             tx_line_bit,
   output logic             tx_line_en,
   output logic             tx_frame_start,
   output logic             int_n
);

   // ------------------------------------------------------------------
   // Register bus slave.
   // ------------------------------------------------------------------
   logic        wait_reg;
   logic [31:0] rdata_reg;
   logic [4:0]  irq_en_reg;
   logic [3:0]  flag_reg;
   logic [3:0]  flag_next;
   logic [2:0]  fmt_reg;
   logic [2:0]  mode_reg;
   logic [7:0]  tx_c_lo_reg;
   logic [5:0]  tx_mc_reg;
   logic [5:0]  tx_sa_reg;
   logic [1:0]  yel_reg;
   logic [3:0]  maint_reg;
   logic [19:0] cap_reg;
   logic [19:0] cap_next;
   logic [19:0] prev_reg;
   logic        int_n_reg;

   wire       bus_req  = avs_read | avs_write;
   wire       wr_en    = avs_write & ~wait_reg & avs_byteenable[0];
   wire [7:0] wdat     = avs_writedata[7:0];
   wire       wr_irq   = wr_en & (avs_address == toe_pkg::OFS_IRQ_EN);
   wire       wr_flags = wr_en & (avs_address == toe_pkg::OFS_FLAGS);
   wire       wr_fmt   = wr_en & (avs_address == toe_pkg::OFS_FMT);
   wire       wr_mode  = wr_en & (avs_address == toe_pkg::OFS_MODE);
   wire       wr_txc   = wr_en & (avs_address == toe_pkg::OFS_TXC_LO);
   wire       wr_txmc  = wr_en & (avs_address == toe_pkg::OFS_TXMC);
   wire       wr_txsa  = wr_en & (avs_address == toe_pkg::OFS_TXSA);
   wire       wr_yel   = wr_en & (avs_address == toe_pkg::OFS_YEL);
   wire       wr_maint = wr_en & (avs_address == toe_pkg::OFS_MAINT);

   // Read multiplexer; unmapped words read as zero.
   logic [7:0] rd_mux;
   always_comb begin
      case (avs_address)
         toe_pkg::OFS_RXC_LO: rd_mux = cap_reg[7:0];
         toe_pkg::OFS_RXMC:   rd_mux = {2'h0, cap_reg[13:8]};
         toe_pkg::OFS_RXSA:   rd_mux = {2'h0, cap_reg[19:14]};
         toe_pkg::OFS_IRQ_EN: rd_mux = {3'h0, irq_en_reg};
         toe_pkg::OFS_FLAGS:  rd_mux = {4'h0, flag_reg};
         toe_pkg::OFS_FMT:    rd_mux = {5'h0, fmt_reg};
         toe_pkg::OFS_MODE:   rd_mux = {5'h0, mode_reg};
         toe_pkg::OFS_TXC_LO: rd_mux = tx_c_lo_reg;
         toe_pkg::OFS_TXMC:   rd_mux = {2'h0, tx_mc_reg};
         toe_pkg::OFS_TXSA:   rd_mux = {2'h0, tx_sa_reg};
         toe_pkg::OFS_YEL:    rd_mux = {6'h0, yel_reg};
         toe_pkg::OFS_MAINT:  rd_mux = {4'h0, maint_reg};
         default:             rd_mux = 8'h00;
      endcase
   end

   // One wait state: the request is answered at the second edge it is seen.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         wait_reg <= ~(bus_req & wait_reg);
         if (bus_req & wait_reg) begin
            rdata_reg <= {24'h00_0000, rd_mux};
         end
      end
   end

   // Control registers written by software.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         irq_en_reg  <= toe_pkg::RST_VAL[4:0];
         fmt_reg     <= toe_pkg::RST_VAL[2:0];
         mode_reg    <= toe_pkg::RST_VAL[2:0];
         tx_c_lo_reg <= toe_pkg::RST_VAL;
         tx_mc_reg   <= toe_pkg::RST_VAL[5:0];
         tx_sa_reg   <= toe_pkg::RST_VAL[5:0];
         yel_reg     <= toe_pkg::RST_VAL[1:0];
         maint_reg   <= toe_pkg::RST_VAL[3:0];
      end else begin
         if (wr_irq)   irq_en_reg  <= wdat[4:0];
         if (wr_fmt)   fmt_reg     <= wdat[2:0];
         if (wr_mode)  mode_reg    <= wdat[2:0];
         if (wr_txc)   tx_c_lo_reg <= wdat;
         if (wr_txmc)  tx_mc_reg   <= wdat[5:0];
         if (wr_txsa)  tx_sa_reg   <= wdat[5:0];
         if (wr_yel)   yel_reg     <= wdat[1:0];
         if (wr_maint) maint_reg   <= wdat[3:0];
      end
   end

   // ------------------------------------------------------------------
   // Receive overhead capture and change indication.
   // ------------------------------------------------------------------
   wire [19:0] rx_new = {rx_switch, rx_alarm, rx_maint, rx_concentrator};
   wire        rx_upd = rx_frame_end & rx_slc_sync;
   wire        deb_on = irq_en_reg[toe_pkg::IRQ_DEB_BIT];

   // Each field refreshes on every frame end with sync, or only on two equal such frames with debounce.
   logic [19:0] upd_mask;
   logic [3:0]  chg;
   always_comb begin
      upd_mask = 20'h0_0000;
      chg      = 4'h0;
      for (int i = 0; i < 4; i++) begin
         if (!deb_on || (((rx_new ^ prev_reg) & toe_pkg::FIELD_MASK[i]) == 20'h0_0000)) begin
            upd_mask = upd_mask | toe_pkg::FIELD_MASK[i];
         end
      end
      cap_next = rx_upd ? ((rx_new & upd_mask) | (cap_reg & ~upd_mask)) : cap_reg;
      for (int i = 0; i < 4; i++) begin
         chg[i] = ((cap_next ^ cap_reg) & toe_pkg::FIELD_MASK[i]) != 20'h0_0000;
      end
   end

   // A change arriving with a clearing write still sets its flag.
   assign flag_next = (flag_reg & ~(wr_flags ? wdat[3:0] : 4'h0)) | chg;

   // Capture, flags and the interrupt pin.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cap_reg   <= 20'h0_0000;
         prev_reg  <= 20'h0_0000;
         flag_reg  <= 4'h0;
         int_n_reg <= 1'b1;
      end else begin
         cap_reg   <= cap_next;
         flag_reg  <= flag_next;
         int_n_reg <= ~|(flag_next & irq_en_reg[3:0]);
         if (rx_upd) begin
            prev_reg <= rx_new;
         end
      end
   end

   // ------------------------------------------------------------------
   // Transmit frame position.
   // ------------------------------------------------------------------
   toe_pkg::toe_format_type fmt;
   logic [7:0] pos_reg;
   logic [6:0] frm_reg;
   logic [6:0] mf_last;
   logic [3:0] dl_idx_reg;
   logic [5:0] crc_acc_reg;
   logic [5:0] crc_hold_reg;
   logic       f_last_reg;
   logic       out_last_reg;
   logic       slip_prev_reg;
   logic       slip_pend_reg;
   logic       slip_sel_reg;
   logic       line_bit_reg;
   logic       line_en_reg;
   logic       fstart_reg;

   assign fmt = toe_pkg::toe_format_type'(fmt_reg[1:0]);

   always_comb begin
      case (fmt)
         toe_pkg::TOE_ESF: mf_last = toe_pkg::ESF_LAST;
         toe_pkg::TOE_SLC: mf_last = toe_pkg::SLC_LAST;
         default:          mf_last = toe_pkg::SF_LAST;
      endcase
   end

   // Advances a frame position by one bit, wrapping frame and multiframe.
   function automatic logic [14:0] toe_adv(input logic [7:0] p,
                                           input logic [6:0] f,
                                           input logic [6:0] last);
      logic [6:0] fn;
      fn = (f >= last) ? 7'h00 : 7'(f + 7'h01);
      if (p >= toe_pkg::FRAME_LAST) begin
         toe_adv = {fn, 8'h00};
      end else begin
         toe_adv = {f, 8'(p + 8'h01)};
      end
   endfunction : toe_adv

   wire [14:0] step1 = toe_adv(pos_reg, frm_reg, mf_last);
   wire [14:0] step2 = toe_adv(step1[7:0], step1[14:8], mf_last);

   // ------------------------------------------------------------------
   // Transmit overhead generation.
   // ------------------------------------------------------------------
   wire        gen_on  = ~mode_reg[toe_pkg::MODE_GENOFF];
   wire        dl_on   = gen_on & ~mode_reg[toe_pkg::MODE_DLBYP];
   wire        crc_on  = gen_on & ~mode_reg[toe_pkg::MODE_CRCOFF];
   wire        yel_on  = yel_reg[toe_pkg::YEL_MAN] |
                         (yel_reg[toe_pkg::YEL_AUTO] & rx_red_alarm);
   wire        f_pos   = (pos_reg == 8'h00);
   wire [5:0]  slc_k   = frm_reg[6:1];
   wire [2:0]  sub_idx = frm_reg[4:2];
   wire [19:0] ovh_vec = {tx_sa_reg, tx_mc_reg[5:3], tx_mc_reg[2:0], tx_c_lo_reg};
   wire [4:0]  ovh_idx = 5'(slc_k - toe_pkg::SLC_C_FIRST);
   wire [15:0] idle_w  = fmt_reg[toe_pkg::FMT_J1_BIT] ? toe_pkg::IDLE_J1 : toe_pkg::IDLE_T1;
   wire        dl_src  = tx_dl_valid ? tx_dl_bit : idle_w[4'hf - dl_idx_reg];
   wire        esf_dl  = (fmt == toe_pkg::TOE_ESF) & f_pos & ~frm_reg[0];

   // SLC-96 Fs bits: sync pattern, then C, M, A and S fields, then spares.
   logic slc_fs;
   always_comb begin
      if (slc_k < toe_pkg::SLC_C_FIRST) begin
         slc_fs = toe_pkg::SLC_SYNC[slc_k[3:0]];
      end else if (slc_k == toe_pkg::SLC_SYNC_LAST) begin
         slc_fs = toe_pkg::SLC_SYNC[11];
      end else if (!dl_on) begin
         slc_fs = tx_data_in;
      end else if (slc_k < toe_pkg::SLC_SPARE_FIRST) begin
         slc_fs = ovh_vec[ovh_idx];
      end else begin
         slc_fs = 1'b0;
      end
   end

   // F bit value for the current frame in each format.
   logic f_gen;
   always_comb begin
      case (fmt)
         toe_pkg::TOE_ESF: begin
            if (!frm_reg[0]) begin
               if (yel_on) begin
                  f_gen = toe_pkg::ESF_YELLOW[4'hf - dl_idx_reg];
               end else begin
                  f_gen = dl_on ? dl_src : tx_data_in;
               end
            end else if (!frm_reg[1]) begin
               f_gen = crc_on ? crc_hold_reg[3'h5 - sub_idx] : tx_data_in;
            end else begin
               f_gen = toe_pkg::FAS_PATTERN[sub_idx];
            end
         end
         toe_pkg::TOE_SLC: f_gen = frm_reg[0] ? slc_fs : ~frm_reg[1];
         default:          f_gen = frm_reg[0] ? toe_pkg::FS_SF_PATTERN[frm_reg[3:1]] : ~frm_reg[1];
      endcase
   end

   // Payload and overhead merge ahead of the line overwrites.
   logic bit_pre;
   always_comb begin
      bit_pre = tx_data_in;
      if (f_pos) begin
         bit_pre = gen_on ? f_gen : tx_data_in;
      end else if (gen_on) begin
         if (fmt == toe_pkg::TOE_DM && dl_on && pos_reg == toe_pkg::DBIT_POS) begin
            bit_pre = dl_src;
         end
         if (maint_reg[toe_pkg::MNT_MIMIC] && pos_reg == toe_pkg::MIMIC_POS) begin
            bit_pre = f_last_reg;
         end
         if (yel_on && fmt != toe_pkg::TOE_ESF && pos_reg[2:0] == toe_pkg::YEL_CH_BIT) begin
            bit_pre = 1'b0;
         end
      end
   end

   // Line overwrites: zeros take priority over ones.
   wire slip_rep = slip_pend_reg & slip_sel_reg;
   wire slip_del = slip_pend_reg & ~slip_sel_reg;
   wire bit_fin  = maint_reg[toe_pkg::MNT_ZERO] ? 1'b0 :
                   maint_reg[toe_pkg::MNT_ONES] ? 1'b1 :
                   (slip_rep ? out_last_reg : bit_pre);

   // CRC-6 over the multiframe with every F bit counted as one.
   wire       crc_in   = f_pos | bit_pre;
   wire       crc_fb   = crc_in ^ crc_acc_reg[5];
   wire [5:0] crc_step = {crc_acc_reg[4:0], 1'b0} ^ (crc_fb ? toe_pkg::CRC_POLY : 6'h00);
   wire       mf_end   = (fmt == toe_pkg::TOE_ESF) & (frm_reg == toe_pkg::ESF_LAST) &
                         (pos_reg == toe_pkg::FRAME_LAST);

   // Alignment slip request from any toggle of the control bit.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         slip_prev_reg <= 1'b0;
         slip_pend_reg <= 1'b0;
         slip_sel_reg  <= 1'b0;
      end else begin
         slip_prev_reg <= maint_reg[toe_pkg::MNT_SLIP];
         if (slip_prev_reg != maint_reg[toe_pkg::MNT_SLIP]) begin
            slip_pend_reg <= 1'b1;
         end else if (tx_bit_en) begin
            slip_pend_reg <= 1'b0;
         end
         if (tx_bit_en) begin
            slip_sel_reg <= ~slip_sel_reg;
         end
      end
   end

   // Position counters: a repeat holds the position, a deletion skips one.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         pos_reg <= 8'h00;
         frm_reg <= 7'h00;
      end else if (tx_bit_en && !slip_rep) begin
         pos_reg <= slip_del ? step2[7:0] : step1[7:0];
         frm_reg <= slip_del ? step2[14:8] : step1[14:8];
      end
   end

   // Datalink pattern index, CRC state and the line output.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         dl_idx_reg   <= 4'h0;
         crc_acc_reg  <= 6'h00;
         crc_hold_reg <= 6'h00;
         f_last_reg   <= 1'b0;
         out_last_reg <= 1'b0;
         line_bit_reg <= 1'b0;
         line_en_reg  <= 1'b0;
         fstart_reg   <= 1'b0;
      end else begin
         line_en_reg <= tx_bit_en;
         fstart_reg  <= tx_bit_en & f_pos & (frm_reg == 7'h00) & ~slip_rep;
         if (tx_bit_en) begin
            line_bit_reg <= bit_fin;
            out_last_reg <= bit_fin;
            if (f_pos) begin
               f_last_reg <= bit_pre;
            end
            if (esf_dl && !slip_rep) begin
               dl_idx_reg <= 4'(dl_idx_reg + 4'h1);
            end
            if (mf_end) begin
               crc_hold_reg <= crc_step;
               crc_acc_reg  <= 6'h00;
            end else if (fmt == toe_pkg::TOE_ESF && !slip_rep) begin
               crc_acc_reg <= crc_step;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Output drive.
   // ------------------------------------------------------------------
   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign tx_line_bit     = line_bit_reg;
   assign tx_line_en      = line_en_reg;
   assign tx_frame_start  = fstart_reg;
   assign int_n           = int_n_reg;

endmodule : toe_overhead

// *** sim/toe_overhead_monitor.sv ***
// Port checker for the overhead extract and insert block.
module toe_overhead_monitor (
   input wire logic        clk_sys,
   input wire logic        nrst,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic        avs_waitrequest,
   input wire logic        rx_slc_sync,
   input wire logic        rx_frame_end,
   input wire logic        tx_line_bit,
   input wire logic        tx_line_en,
   input wire logic        tx_frame_start,
   input wire logic        int_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ovw_reg;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Shadows the two overwrite controls from completed writes.
   always_ff @(posedge clk_sys) begin
      if (!nrst) ovw_reg <= 2'h0;
      else if (avs_write && !avs_waitrequest && avs_byteenable[0]
               && avs_address == toe_pkg::OFS_MAINT) ovw_reg <= avs_writedata[1:0];
   end
   property p_bus_answer;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
   property p_bus_once;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_bus_once: assert property (p_bus_once) else $error("bus answer too long");
   property p_int_fall;
      $fell(int_n) |-> $past(rx_frame_end && rx_slc_sync) || $past(avs_write)
         || $past(avs_write, 2);
   endproperty
   a_int_fall: assert property (p_int_fall) else $error("interrupt without cause");
   property p_int_rise;
      $rose(int_n) |-> $past(avs_write) || $past(avs_write, 2) || $past(!nrst);
   endproperty
   a_int_rise: assert property (p_int_rise) else $error("interrupt cleared alone");
   property p_sync_hold;
      !rx_slc_sync && !avs_write && !$past(avs_write) |=> $stable(int_n);
   endproperty
   a_sync_hold: assert property (p_sync_hold) else $error("change without sync");
   property p_zero;
      tx_line_en && $past(ovw_reg[1]) |-> !tx_line_bit;
   endproperty
   a_zero: assert property (p_zero) else $error("one sent under zero overwrite");
   property p_ones;
      tx_line_en && $past(ovw_reg) == 2'h1 |-> tx_line_bit;
   endproperty
   a_ones: assert property (p_ones) else $error("zero sent under ones overwrite");
   property p_frame_start;
      tx_frame_start |-> tx_line_en;
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("start off a bit");
   c_int_low: cover property ($fell(int_n));
   c_zero: cover property (tx_line_en && ovw_reg == 2'h2);
   c_start: cover property (tx_frame_start);
endmodule : toe_overhead_monitor
bind toe_overhead toe_overhead_monitor i_toe_overhead_monitor (
   .clk_sys, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
   .avs_waitrequest, .rx_slc_sync, .rx_frame_end, .tx_line_bit, .tx_line_en,
   .tx_frame_start, .int_n);

// *** sim/toe_line_partner.sv ***
// Remote line terminal model that paces and collects the transmit stream.
module toe_line_partner (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic slow,
   input  wire logic pay,
   output logic      tx_bit_en,
   output logic      tx_data_in,
   input  wire logic tx_line_bit,
   input  wire logic tx_line_en,
   input  wire logic tx_frame_start
);
   timeunit 1ns;
   timeprecision 1ps;
   int          pos_reg, frm_reg, run_cnt, mf_len, mf_cnt, ones_cnt, bits_cnt;
   logic [71:0] f_vec, m_vec;
   logic        ph_reg;
   // Paces bits every cycle, or every other cycle when slow.
   always_ff @(posedge clk_sys) begin
      ph_reg     <= nrst && !ph_reg;
      tx_bit_en  <= nrst && (!slow || ph_reg);
      tx_data_in <= pay;
   end
   // Counts line bits and keeps the first two bits of every frame.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         mf_cnt   <= 0;
         ones_cnt <= 0;
         bits_cnt <= 0;
      end else if (tx_line_en) begin
         bits_cnt <= bits_cnt + 1;
         ones_cnt <= ones_cnt + int'(tx_line_bit);
         run_cnt  <= run_cnt + 1;
         pos_reg  <= (pos_reg == 192) ? 0 : pos_reg + 1;
         frm_reg  <= (pos_reg == 192) ? frm_reg + 1 : frm_reg;
         if (pos_reg == 0) f_vec[frm_reg] <= tx_line_bit;
         if (pos_reg == 1) m_vec[frm_reg] <= tx_line_bit;
         if (tx_frame_start) begin
            mf_cnt   <= mf_cnt + 1;
            mf_len   <= run_cnt;
            run_cnt  <= 1;
            pos_reg  <= 1;
            frm_reg  <= 0;
            f_vec[0] <= tx_line_bit;
         end
      end
   end
endmodule : toe_line_partner

// *** sim/test_t1_overhead_extract_insert.sv ***
// Self-checking bench of the overhead extract and insert block.
module test_t1_overhead_extract_insert;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] RST_ADDR [8] = '{toe_pkg::OFS_IRQ_EN, toe_pkg::OFS_FLAGS,
      toe_pkg::OFS_MODE, toe_pkg::OFS_TXC_LO, toe_pkg::OFS_TXMC, toe_pkg::OFS_TXSA,
      toe_pkg::OFS_MAINT, 8'h00};
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'h1;
   logic        rx_slc_sync = 1'b1;
   logic        rx_frame_end = 1'b0;
   logic [19:0] rx_vec = 20'h0;
   logic        slow = 1'b0;
   logic        pay = 1'b0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest, tx_bit_en, tx_data_in, tx_line_bit, tx_line_en;
   logic        tx_frame_start, int_n;
   logic [7:0]  q_dummy;
   logic [35:0] fs_seen;
   int          miscompares = 0, checks_done = 0, cyc = 0;
   int          mark, n1, nb;
   toe_overhead i_toe_overhead (
      .clk_sys, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_slc_sync, .rx_frame_end,
      .rx_concentrator (rx_vec[10:0]), .rx_maint (rx_vec[13:11]), .rx_alarm (rx_vec[15:14]),
      .rx_switch (rx_vec[19:16]), .rx_red_alarm (1'b0), .tx_bit_en, .tx_data_in,
      .tx_dl_valid (1'b0), .tx_dl_bit (1'b0), .tx_line_bit, .tx_line_en, .tx_frame_start,
      .int_n);
   toe_line_partner i_toe_line_partner (
      .clk_sys, .nrst, .slow, .pay, .tx_bit_en, .tx_data_in, .tx_line_bit, .tx_line_en,
      .tx_frame_start);
   // A 200 MHz clock.
   always #2.5 clk_sys = ~clk_sys;
   task automatic give_verdict();
      if (miscompares == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict
   // Ends a hung run as a failure.
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 95000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // One bus cycle, held until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [7:0] q);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'h1, q_dummy);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00, 4'h1, q_dummy);
      check($sformatf("register %h", a), 72'(q_dummy), 72'(e));
   endtask : rd
   task automatic int_is(input logic e);
      repeat (2) @(posedge clk_sys);
      check("interrupt pin", 72'(int_n), 72'(e));
   endtask : int_is
   // One received superframe; fields are driven inverted outside it.
   task automatic rx(input logic sy, input logic [19:0] v);
      @(posedge clk_sys);
      rx_slc_sync <= sy;
      rx_frame_end <= 1'b1;
      rx_vec <= v;
      @(posedge clk_sys);
      rx_frame_end <= 1'b0;
      rx_vec <= ~v;
   endtask : rx
   task automatic wait_mf(input int n);
      mark = i_toe_line_partner.mf_cnt;
      while (i_toe_line_partner.mf_cnt < mark + n) @(posedge clk_sys);
   endtask : wait_mf
   task automatic span();
      repeat (20) @(posedge clk_sys);
      n1 = i_toe_line_partner.ones_cnt;
      nb = i_toe_line_partner.bits_cnt;
      repeat (400) @(posedge clk_sys);
      n1 = i_toe_line_partner.ones_cnt - n1;
      nb = i_toe_line_partner.bits_cnt - nb;
   endtask : span
   task automatic grab_mf();
      wait_mf(2);
      for (int k = 1; k <= 36; k++) fs_seen[k-1] = i_toe_line_partner.f_vec[2*k-1];
   endtask : grab_mf
   // Main sequence.
   initial begin
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      foreach (RST_ADDR[i]) rd(RST_ADDR[i], toe_pkg::RST_VAL);
      bus(1'b1, toe_pkg::OFS_IRQ_EN, 8'hff, 4'h0, q_dummy);
      rd(toe_pkg::OFS_IRQ_EN, 8'h00);
      wr(toe_pkg::OFS_IRQ_EN, 8'h04);
      rx(1'b1, {4'h9, 2'h2, 3'h5, 11'h4b5});
      rd(toe_pkg::OFS_RXC_LO, 8'hb5);
      rd(toe_pkg::OFS_RXMC, 8'h2c);
      rd(toe_pkg::OFS_RXSA, 8'h26);
      rd(toe_pkg::OFS_FLAGS, 8'h0f);
      int_is(1'b0);
      wr(toe_pkg::OFS_IRQ_EN, 8'h00);
      int_is(1'b1);
      wr(toe_pkg::OFS_FLAGS, 8'h0b);
      rd(toe_pkg::OFS_FLAGS, 8'h04);
      wr(toe_pkg::OFS_FLAGS, 8'h04);
      rx(1'b1, {4'h9, 2'h1, 3'h5, 11'h4b5});
      rd(toe_pkg::OFS_FLAGS, 8'h08);
      rd(toe_pkg::OFS_RXSA, 8'h25);
      wr(toe_pkg::OFS_IRQ_EN, 8'h08);
      int_is(1'b0);
      wr(toe_pkg::OFS_FLAGS, 8'h08);
      int_is(1'b1);
      rx(1'b0, {4'h6, 2'h1, 3'h2, 11'h34a});
      rd(toe_pkg::OFS_RXSA, 8'h25);
      rd(toe_pkg::OFS_FLAGS, 8'h00);
      wr(toe_pkg::OFS_IRQ_EN, 8'h10);
      rx(1'b1, {4'h6, 2'h1, 3'h2, 11'h34a});
      rd(toe_pkg::OFS_RXSA, 8'h25);
      rx(1'b1, {4'h6, 2'h1, 3'h2, 11'h34a});
      rd(toe_pkg::OFS_RXSA, 8'h19);
      rd(toe_pkg::OFS_RXMC, 8'h13);
      slow <= 1'b1;
      pay <= 1'b1;
      wr(toe_pkg::OFS_MAINT, 8'h02);
      span();
      check("ones under zero overwrite", 72'(n1), 72'h0);
      pay <= 1'b0;
      wr(toe_pkg::OFS_MAINT, 8'h01);
      span();
      check("ones under ones overwrite", 72'(n1), 72'(nb));
      pay <= 1'b1;
      wr(toe_pkg::OFS_MAINT, 8'h03);
      span();
      check("ones under both overwrites", 72'(n1), 72'h0);
      wr(toe_pkg::OFS_MAINT, 8'h00);
      wr(toe_pkg::OFS_MODE, 8'h01);
      span();
      check("ones with generation off", 72'(n1), 72'(nb));
      slow <= 1'b0;
      pay <= 1'b0;
      wr(toe_pkg::OFS_MODE, 8'h00);
      wait_mf(2);
      check("multiframe length", 72'(i_toe_line_partner.mf_len), 72'(2316));
      wr(toe_pkg::OFS_MAINT, 8'h04);
      wait_mf(1);
      n1 = i_toe_line_partner.mf_len;
      check("slipped length", 72'(n1 == 2315 || n1 == 2317), 72'h1);
      wr(toe_pkg::OFS_FMT, 8'h03);
      wr(toe_pkg::OFS_TXC_LO, 8'hb5);
      wr(toe_pkg::OFS_TXMC, 8'h2c);
      wr(toe_pkg::OFS_TXSA, 8'h26);
      wr(toe_pkg::OFS_MAINT, 8'h0c);
      grab_mf();
      check("superframe overhead", 72'(fs_seen), 72'({toe_pkg::SLC_SYNC[11], 4'h0, 4'h9,
            2'h2, 3'h5, 11'h4b5, toe_pkg::SLC_SYNC[10:0]}));
      check("copied bits", i_toe_line_partner.m_vec, i_toe_line_partner.f_vec);
      wr(toe_pkg::OFS_MODE, 8'h04);
      wr(toe_pkg::OFS_MAINT, 8'h04);
      grab_mf();
      check("bypassed overhead", 72'(fs_seen),
            72'({toe_pkg::SLC_SYNC[11], 24'h0, toe_pkg::SLC_SYNC[10:0]}));
      give_verdict();
   end
endmodule : test_t1_overhead_extract_insert
